// ==== hdl/qdac_consts.svh ====
// Purpose: Shared constants of the quad converter serial link
// Assumes: ref_clk at 250 MHz, link clock made by the host end
// Notes:   Times are in ns, cycle counts derive from them
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

`define QDAC_WORD_BITS   16
`define QDAC_CNT_LAST    4'hF
`define QDAC_ADDR_HI     15
`define QDAC_ADDR_LO     14
`define QDAC_MODE_HI     13
`define QDAC_MODE_LO     12
`define QDAC_CODE_HI     11
`define QDAC_CODE_LO     4
`define QDAC_CLK_MHZ     250
`define QDAC_HALF_NS     80
`define QDAC_HALF_CYC    ((`QDAC_HALF_NS * `QDAC_CLK_MHZ + 999) / 1000)
`define QDAC_SYNC_HI_NS  80
`define QDAC_SYNC_HI_CYC ((`QDAC_SYNC_HI_NS * `QDAC_CLK_MHZ + 999) / 1000)
`define QDAC_WAKE_NS     6000
`define QDAC_WAKE_CYC    ((`QDAC_WAKE_NS * `QDAC_CLK_MHZ + 999) / 1000)
`define QDAC_CMD_OFS     32'h0000_0000
`define QDAC_STAT_OFS    32'h0000_0004
`define QDAC_LEN_HI      20
`define QDAC_LEN_LO      16

`endif

// ==== hdl/qdac_dev.sv ====
// Purpose: Converter end: frame decode, channel stages, power-down
// Assumes: Host keeps link timing; link sampled by ref_clk
// Notes:   Codes out are digital; Vout = Vref * code / 256
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "qdac_consts.svh"
module qdac_dev (
  input  wire logic         ref_clk,        // System clock, 250 MHz
  input  wire logic         sys_rst,        // Synchronous reset, high
  qdac_if.dev               link,           // Serial link from host
  output qdac_pkg::qdac_codes_t analog_outputs, // Output stage codes
  output logic              powered_down,   // All channels shut down
  output qdac_pkg::qdac_term_t out_term,    // Termination while down
  output logic              waking,         // Wake-up time running
  output logic              frame_done,     // Pulse, word executed
  output logic              frame_abort     // Pulse, partial frame lost
);
  import qdac_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_SHIFT = 2'b01,
    D_DONE  = 2'b10
  } qdac_dstate_t;

  localparam logic [10:0] WAKE_LOAD = 11'(`QDAC_WAKE_CYC - 1);

  qdac_dstate_t state_reg;
  qdac_dstate_t state_next;
  logic [2:0]   lvl;
  logic         sync_l;
  logic         sclk_l;
  logic         din_l;
  logic         sync_prev_reg;
  logic         sclk_prev_reg;
  logic [14:0]  shift_reg;
  logic [3:0]   cnt_reg;
  qdac_codes_t  in_reg;
  qdac_codes_t  in_next;
  qdac_codes_t  out_reg;
  qdac_codes_t  out_next;
  logic         pd_reg;
  qdac_term_t   term_reg;
  logic [10:0]  wake_reg;
  logic         done_reg;
  logic         abort_reg;

  // Link pins pass three stages; all reset to the parked low level
  // so that release of reset shows no false select fall
  qdac_sync #(
    .WIDTH (3),
    .RST   (3'h0)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({link.din, link.sclk, link.sync_n}),
    .lvl_out  (lvl)
  );

  assign sync_l = lvl[0];
  assign sclk_l = lvl[1];
  assign din_l  = lvl[2];

  // Edge decode on the filtered levels
  wire sync_fall = sync_prev_reg & ~sync_l;
  wire sync_rise = ~sync_prev_reg & sync_l;
  wire sclk_fall = sclk_prev_reg & ~sclk_l;

  // Word as it stands after the current bit is shifted in
  wire [15:0] word_w = {shift_reg, din_l};
  wire [1:0]  addr_w = word_w[`QDAC_ADDR_HI:`QDAC_ADDR_LO];
  wire [1:0]  mode_b = word_w[`QDAC_MODE_HI:`QDAC_MODE_LO];
  wire [7:0]  code_w = word_w[`QDAC_CODE_HI:`QDAC_CODE_LO];
  wire qdac_mode_t mode_w = qdac_mode_t'(mode_b);

  // A rise in the same cycle as a fall counts as an abort first
  wire in_frame  = (state_reg == D_SHIFT) & ~sync_l;
  wire take_bit  = in_frame & sclk_fall;
  wire exec_w    = take_bit & (cnt_reg == `QDAC_CNT_LAST);
  wire is_pd     = (mode_w == QDAC_PWR_DOWN);
  wire is_update = (mode_w == QDAC_LOAD_UPD) | (mode_w == QDAC_ALL_UPD);
  wire leave_pd  = exec_w & ~is_pd & pd_reg;

  // Frame sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      D_IDLE:
      begin
        if (sync_fall)
          state_next = D_SHIFT;
      end
      D_SHIFT:
      begin
        if (sync_l)
          state_next = D_IDLE;
        else if (exec_w)
          state_next = D_DONE;
      end
      D_DONE:
      begin
        if (sync_l)
          state_next = D_IDLE;
      end
      default:
        state_next = D_IDLE;
    endcase
  end

  // Per channel: input stage loads, output stage takes updates
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      wire hit = (addr_w == 2'(ch));
      wire load_one = exec_w & hit & ~is_pd & (mode_w != QDAC_ALL_UPD);
      wire load_all = exec_w & (mode_w == QDAC_ALL_UPD);
      // Power-down frames never touch the stages
      assign in_next[ch] = (load_one | load_all) ? code_w : in_reg[ch];
      assign out_next[ch] = (exec_w & is_update) ? in_next[ch]
                                                 : out_reg[ch];
    end
  endgenerate

  // Link edge history and sequencer state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_prev_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      state_reg     <= D_IDLE;
    end
    else
    begin
      sync_prev_reg <= sync_l;
      sclk_prev_reg <= sclk_l;
      state_reg     <= state_next;
    end
  end

  // Shift register and bit count; frame start restarts the count
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      shift_reg <= 15'h0000;
      cnt_reg   <= 4'h0;
    end
    else if (state_reg == D_IDLE)
    begin
      cnt_reg <= 4'h0;
    end
    else if (take_bit)
    begin
      shift_reg <= word_w[14:0];
      cnt_reg   <= cnt_reg + 4'h1;
    end
  end

  // Channel stages: cleared at reset, kept across power-down
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      in_reg  <= '0;
      out_reg <= '0;
    end
    else
    begin
      in_reg  <= in_next;
      out_reg <= out_next;
    end
  end

  // Power state and termination only change on a whole word
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pd_reg   <= 1'b0;
      term_reg <= QDAC_TERM_HIZ;
    end
    else if (exec_w)
    begin
      pd_reg <= is_pd;
      if (is_pd)
        term_reg <= qdac_term_t'(addr_w);
    end
  end

  // Wake timer: amplifiers need time before outputs are trusted
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      wake_reg <= 11'h000;
    else if (leave_pd)
      wake_reg <= WAKE_LOAD;
    else if (exec_w & is_pd)
      wake_reg <= 11'h000;
    else if (wake_reg != 11'h000)
      wake_reg <= wake_reg - 11'h001;
  end

  // Event pulses, one cycle each
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      done_reg  <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      done_reg  <= exec_w;
      abort_reg <= (state_reg == D_SHIFT) & sync_l;
    end
  end

  // Outputs straight from registers except waking, a compare on wake_reg; code maps to Vref*code/256
  assign analog_outputs = out_reg;
  assign powered_down   = pd_reg;
  assign out_term       = term_reg;
  assign waking         = (wake_reg != 11'h000);
  assign frame_done     = done_reg;
  assign frame_abort    = abort_reg;

endmodule : qdac_dev

// ==== hdl/qdac_host.sv ====
// Purpose: Host end: APB command registers drive the serial link
// Assumes: APB slave with zero wait states
// Notes:   Link clock made here by a divider of ref_clk
`timescale 1ns/10ps
`include "qdac_consts.svh"
module qdac_host (
  input  wire logic        ref_clk, // System clock, 250 MHz
  input  wire logic        sys_rst, // Synchronous reset, high
  input  wire logic [31:0] paddr,   // APB address
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB direction
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error, unmapped address
  qdac_if.host             link     // Serial link to converter
);
  import qdac_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PRE  = 3'b001,
    H_LEAD = 3'b010,
    H_HIGH = 3'b011,
    H_LOW  = 3'b100,
    H_POST = 3'b101
  } qdac_hstate_t;

  localparam logic [7:0] HALF_LOAD = 8'(`QDAC_HALF_CYC - 1);
  localparam logic [7:0] SYNC_LOAD = 8'(`QDAC_SYNC_HI_CYC - 1);

  qdac_hstate_t state_reg;
  logic [7:0]   tcnt_reg;
  logic [15:0]  word_reg;
  logic [15:0]  shift_reg;
  logic [4:0]   len_reg;
  logic [4:0]   sent_reg;
  logic [15:0]  frames_reg;
  logic [31:0]  rdata_reg;
  logic         sync_n_reg;
  logic         sclk_reg;
  logic         din_reg;

  // APB decode; zero wait states
  wire cmd_hit  = (paddr == `QDAC_CMD_OFS);
  wire stat_hit = (paddr == `QDAC_STAT_OFS);
  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire busy     = (state_reg != H_IDLE);
  wire start    = wr_acc & cmd_hit & ~busy;  // Writes while busy are dropped
  wire tdone    = (tcnt_reg == 8'h00);
  wire [4:0] len_w   = pwdata[`QDAC_LEN_HI:`QDAC_LEN_LO];
  wire [4:0] len_eff = (len_w == 5'h00) ? 5'(`QDAC_WORD_BITS) : len_w;
  wire [31:0] cmd_rd  = {11'h000, len_reg, word_reg};
  wire [31:0] stat_rd = {frames_reg, 15'h0000, busy};
  wire [31:0] rd_mux  = cmd_hit ? cmd_rd : (stat_hit ? stat_rd : 32'h0000_0000);

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_reg <= 32'h0000_0000;
    else if (setup)
      rdata_reg <= rd_mux;
  end

  // Link sequencer: select high, select low, then bit periods
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg  <= H_IDLE;
      tcnt_reg   <= 8'h00;
      word_reg   <= 16'h0000;
      shift_reg  <= 16'h0000;
      len_reg    <= 5'h00;
      sent_reg   <= 5'h00;
      frames_reg <= 16'h0000;
      sync_n_reg <= 1'b0;
      sclk_reg   <= 1'b0;
      din_reg    <= 1'b0;
    end
    else
    begin
      if (~tdone)
        tcnt_reg <= tcnt_reg - 8'h01;
      case (state_reg)
        H_IDLE:
        begin
          sync_n_reg <= 1'b0;
          din_reg    <= 1'b0;
          if (start)
          begin
            word_reg   <= pwdata[15:0];
            shift_reg  <= pwdata[15:0];
            len_reg    <= len_eff;
            sent_reg   <= 5'h00;
            sync_n_reg <= 1'b1;
            tcnt_reg   <= SYNC_LOAD;
            state_reg  <= H_PRE;
          end
        end
        H_PRE:
        begin
          if (tdone)
          begin
            sync_n_reg <= 1'b0;  // clock is low here
            tcnt_reg   <= HALF_LOAD;
            state_reg  <= H_LEAD;
          end
        end
        H_LEAD, H_LOW:
        begin
          if (tdone & (sent_reg == len_reg))
          begin
            sync_n_reg <= 1'b1;  // when len_reg bits are sent
            tcnt_reg   <= SYNC_LOAD;
            state_reg  <= H_POST;
          end
          else if (tdone)
          begin
            sclk_reg  <= 1'b1;  // launch on rise
            din_reg   <= shift_reg[15];  // MSB first
            shift_reg <= {shift_reg[14:0], 1'b0};
            tcnt_reg  <= HALF_LOAD;
            state_reg <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          if (tdone)
          begin
            sclk_reg  <= 1'b0;  // device samples here
            sent_reg  <= sent_reg + 5'h01;
            tcnt_reg  <= HALF_LOAD;
            state_reg <= H_LOW;
          end
        end
        H_POST:
        begin
          if (tdone)
          begin
            sync_n_reg <= 1'b0;
            din_reg    <= 1'b0;
            frames_reg <= frames_reg + 16'h0001;
            state_reg  <= H_IDLE;
          end
        end
        default:
          state_reg <= H_IDLE;
      endcase
    end
  end

  assign prdata      = rdata_reg;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~(cmd_hit | stat_hit);
  assign link.sync_n = sync_n_reg;
  assign link.sclk   = sclk_reg;
  assign link.din    = din_reg;

endmodule : qdac_host

// ==== hdl/qdac_if.sv ====
// Purpose: Three-wire write link between host and converter
// Assumes: All wires one-way, driven by the host
// Notes:   No clocking block; both ends sample with ref_clk
`timescale 1ns/10ps
interface qdac_if;
  logic sync_n; // Frame select, active low
  logic sclk;   // Shift clock, data taken on falls
  logic din;    // Serial data, MSB first

  modport host (output sync_n, output sclk, output din);
  modport dev  (input sync_n, input sclk, input din);
endinterface : qdac_if

// ==== hdl/qdac_pkg.sv ====
// Purpose: Types shared by both ends of the converter link
// Assumes: Constants come from qdac_consts.svh
// Notes:   Mode and termination codes as carried in the word
package qdac_pkg;

  typedef logic [3:0][7:0] qdac_codes_t;

  typedef enum logic [1:0] {
    QDAC_LOAD     = 2'b00,
    QDAC_LOAD_UPD = 2'b01,
    QDAC_ALL_UPD  = 2'b10,
    QDAC_PWR_DOWN = 2'b11
  } qdac_mode_t;

  typedef enum logic [1:0] {
    QDAC_TERM_HIZ  = 2'b00,
    QDAC_TERM_2K5  = 2'b01,
    QDAC_TERM_100K = 2'b10,
    QDAC_TERM_HIZ2 = 2'b11
  } qdac_term_t;

endpackage : qdac_pkg

// ==== hdl/qdac_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/10ps
module qdac_sync #(
  parameter int         WIDTH = 3,
  parameter logic [2:0] RST   = 3'h0
) (
  input  wire logic             ref_clk, // System clock
  input  wire logic             sys_rst, // Synchronous reset
  input  wire logic [WIDTH-1:0] async_in, // Raw pins
  output logic      [WIDTH-1:0] lvl_out   // Filtered levels
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      // First stage feeds only the second
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          s1_reg  <= RST[g];
          s2_reg  <= RST[g];
          s3_reg  <= RST[g];
          lvl_reg <= RST[g];
        end
        else
        begin
          s1_reg <= async_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            lvl_reg <= s3_reg;
        end
      end
      assign lvl_out[g] = lvl_reg;
    end
  endgenerate

endmodule : qdac_sync

// ==== tb/qdac_asserts.sv ====
// Purpose: Concurrent checks on the serial link and converter outputs
// Assumes: Single ref_clk domain, sys_rst synchronous active high
// Notes:   Sees link wires and converter status only
`timescale 1ns/10ps
module qdac_asserts (
  input wire logic                 ref_clk,        // System clock
  input wire logic                 sys_rst,        // Synchronous reset
  input wire logic                 sync_n,         // Frame select
  input wire logic                 sclk,           // Shift clock
  input wire logic                 din,            // Serial data
  input wire qdac_pkg::qdac_codes_t analog_outputs, // Output stage codes
  input wire logic                 powered_down,   // Shut down flag
  input wire logic                 waking,         // Wake-up running
  input wire logic                 frame_done,     // Word executed
  input wire logic                 frame_abort     // Partial frame lost
);
  import qdac_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_sclk_idle; sync_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("shift clock high out of frame");
  property p_no_fall; $fell(sync_n) |-> !$fell(sclk); endproperty
  a_no_fall: assert property (p_no_fall) else $error("select fell with clock fall");
  property p_sync_hi; $rose(sync_n) |-> sync_n [*3]; endproperty
  a_sync_hi: assert property (p_sync_hi) else $error("select high too short");
  // Data may only move with a clock rise inside a frame, so it is stable at falls
  property p_din_stable; !sync_n && !$past(sync_n) && !$rose(sclk) |-> $stable(din); endproperty
  a_din_stable: assert property (p_din_stable) else $error("data moved off clock rise");
  property p_done_pulse; frame_done |=> !frame_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
  property p_pd_change; $changed(powered_down) |-> frame_done; endproperty
  a_pd_change: assert property (p_pd_change) else $error("power state moved without word");
  property p_out_change; $changed(analog_outputs) |-> frame_done; endproperty
  a_out_change: assert property (p_out_change) else $error("outputs moved without word");
  property p_abort_quiet; frame_abort |-> !frame_done && $stable(analog_outputs); endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("aborted frame changed state");
  property p_wake_cause; $rose(waking) |-> frame_done; endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without a word");
endmodule : qdac_asserts

// ==== tb/quad_dac_serial_control_test.sv ====
// Purpose: Host and converter ends joined, driven over APB
// Assumes: Zero-wait APB host, link clock made by the host
// Notes:   A wire monitor rebuilds each frame from the link
`timescale 1ns/10ps
`include "qdac_consts.svh"
module quad_dac_serial_control_test;
  import qdac_pkg::*;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, powered_down, waking, frame_done, frame_abort;
  qdac_codes_t analog_outputs;
  qdac_term_t  out_term;
  int bad_count = 0, n_checks = 0, cyc = 0;
  logic [15:0] mon_word;
  logic [4:0]  mon_cnt = 0, mon_last = 0;
  logic sclk_q = 0, sync_q = 0, abort_seen = 0, done_seen = 0;
  qdac_if lnk();

  qdac_host u_qdac_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.host));
  qdac_dev u_qdac_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk.dev),
    .analog_outputs(analog_outputs), .powered_down(powered_down), .out_term(out_term),
    .waking(waking), .frame_done(frame_done), .frame_abort(frame_abort));
  qdac_asserts u_qdac_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst), .sync_n(lnk.sync_n),
    .sclk(lnk.sclk), .din(lnk.din), .analog_outputs(analog_outputs),
    .powered_down(powered_down), .waking(waking), .frame_done(frame_done),
    .frame_abort(frame_abort));

  always #2 ref_clk = ~ref_clk;
  // Wire monitor: count restarts at each select fall, kept at the rise
  // Parking select low makes clockless frames whose abort is not counted
  always @(posedge ref_clk)
  begin
    sclk_q <= lnk.sclk;
    sync_q <= lnk.sync_n;
    if (frame_abort && mon_cnt != 5'h0) abort_seen <= 1'b1;
    if (frame_done) done_seen <= 1'b1;
    if (!sync_q && lnk.sync_n) mon_last <= mon_cnt;
    if (sync_q && !lnk.sync_n) mon_cnt <= 5'h0;
    else if (!lnk.sync_n && sclk_q && !lnk.sclk)
    begin
      mon_word <= {mon_word[14:0], lnk.din};
      mon_cnt  <= mon_cnt + 5'h1;
    end
  end
  // Cuts a hang short; a full run takes well under this
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic err);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task wait_idle();
    logic [31:0] q;
    logic e;
    do apb(0, `QDAC_STAT_OFS, 0, q, e); while (q[0] !== 1'b0);
  endtask : wait_idle

  // Sends one word; len 0 or 16 is a full frame, 1 to 15 a short one, 17 and up a long one
  task frame(input logic [15:0] w, input logic [4:0] len);
    logic [31:0] q;
    logic e;
    wait_idle();
    abort_seen = 0;
    done_seen = 0;
    apb(1, `QDAC_CMD_OFS, {11'h0, len, w}, q, e);
    wait_idle();
    chk("falls", mon_last, (len == 0) ? 16 : len);
    chk("done", done_seen, len == 0 || len > 15);
    chk("abort", abort_seen, len != 0 && len < 16);
    if (len == 0) chk("wire word", mon_word, w);
    chk("idle", {lnk.sync_n, lnk.sclk, lnk.din}, 0);
  endtask : frame

  function automatic logic [15:0] mk(logic [1:0] a, qdac_mode_t m, logic [7:0] c);
    return {a, m, c, 4'hF};
  endfunction : mk

  task s_reset();
    logic [31:0] q;
    logic e;
    chk("codes", analog_outputs, 0);
    chk("down", powered_down, 0);
    apb(0, 32'h0000_0040, 0, q, e);
    chk("slverr", e, 1);
  endtask : s_reset

  task s_modes();
    frame(mk(2'h0, QDAC_LOAD, 8'hA5), 0);
    chk("codes", analog_outputs, 0);
    frame(mk(2'h1, QDAC_LOAD_UPD, 8'h3C), 0);
    chk("codes", analog_outputs, 32'h0000_3CA5);
    frame(mk(2'h3, QDAC_ALL_UPD, 8'h7E), 0);
    chk("codes", analog_outputs, 32'h7E7E_7E7E);
  endtask : s_modes

  task s_power();
    for (int t = 0; t < 4; t++)
    begin
      frame(mk(t[1:0], QDAC_PWR_DOWN, 8'h00), 0);
      chk("down", powered_down, 1);
      chk("term", out_term, t);
      chk("codes", analog_outputs, 32'h7E7E_7E7E);
    end
    frame(mk(2'h2, QDAC_LOAD, 8'h11), 0);
    chk("down", powered_down, 0);
    chk("waking", waking, 1);
    repeat (`QDAC_WAKE_CYC) @(posedge ref_clk);
    chk("waking", waking, 0);
    frame(mk(2'h3, QDAC_LOAD_UPD, 8'h22), 0);
    chk("codes", analog_outputs, 32'h2211_7E7E);
  endtask : s_power

  task s_abort();
    logic [31:0] q;
    logic e;
    frame(mk(2'h0, QDAC_ALL_UPD, 8'hFF), 5'd8);
    chk("abort", abort_seen, 1);
    chk("codes", analog_outputs, 32'h2211_7E7E);
    frame(mk(2'h1, QDAC_PWR_DOWN, 8'h00), 5'd15);
    chk("down", powered_down, 0);
    frame(mk(2'h1, QDAC_LOAD_UPD, 8'h5A), 5'd24);
    chk("codes", analog_outputs, 32'h2211_5A7E);
    apb(0, `QDAC_CMD_OFS, 0, q, e);
    chk("cmd", q, 32'h0018_55AF);
    apb(0, `QDAC_STAT_OFS, 0, q, e);
    chk("status", q, 32'h000C_0000);
  endtask : s_abort

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 0;
    s_reset();
    s_modes();
    s_power();
    s_abort();
    complete_run();
  end
endmodule : quad_dac_serial_control_test
